// file: logic/mwsi_pin_select.v
// Pin-function selection for the multi-width serial interface
`timescale 1ns/10ps
`include "mwsi_pin_regs.vh"
// Overview of operation
// - Everything passes serially over four to six pins
// - Single, dual and quad widths supported
// - Pin zero: serial input or data line zero
// - Pin one: serial output or data line one
// - Pin two: write protect unless quad on
// - Pin three: pause, or data three in quad
// - Reset select: pin three resets outside quad or while deselected
// - Pause only while reset select is zero
// - Quad enable removes write protect from pin two
// - Sample on rising clock, change on falling
// - Deselected: ignore data inputs, release all outputs
module mwsi_pin_select
(
   input  wire       mclk,
   input  wire       rst_n,
   input  wire       sckPin,
   input  wire       csPin_n,
   input  wire [3:0] dataPinIn,
   output reg  [3:0] dataPinOut,
   output reg  [3:0] dataPinOe_n,
   input  wire       quadEnableBit,
   input  wire       resetSelectBit,
   input  wire [1:0] xferWidth,
   input  wire       returnPhase,
   input  wire [3:0] returnData,
   output reg  [3:0] rxData,
   output reg        rxValid,
   output reg        txTake,
   output reg        writeProtect_n,
   output reg        pauseActive,
   output reg        hwReset_n,
   output reg  [1:0] pinThreeRole
);
   //*******************************************
   // Input synchronisers
   //*******************************************
   wire [5:0] syncPins;
   wire       sck;
   wire       cs_n;
   wire [3:0] pinIn;
   reg        sckPrev;
   reg        pauseReq;

   mwsi_sync #(.WIDTH(6)) uSync
   (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .din    ({sckPin, csPin_n, dataPinIn}),
      .rstVal (`MWSI_SYNC_RST),
      .dout   (syncPins)
   );

   assign sck   = syncPins[5];
   assign cs_n  = syncPins[4];
   assign pinIn = syncPins[3:0];

   //*******************************************
   // Role decode
   //*******************************************
   function [1:0] role3;
      input qe;
      input rs;
      input csHigh;
      begin
         if (rs && (!qe || csHigh))
            role3 = `MWSI_P3_RESET;
         else if (qe)
            role3 = `MWSI_P3_DATA;
         else if (!rs)
            role3 = `MWSI_P3_PAUSE;
         else
            role3 = `MWSI_P3_NONE;
      end
   endfunction

   // Lanes in use: quad width gets four only with quad enabled, else two
   function [1:0] laneCode;
      input [1:0] width;
      input       qe;
      begin
         case (width)
            `MWSI_WIDTH_SINGLE: laneCode = `MWSI_WIDTH_SINGLE;
            `MWSI_WIDTH_DUAL:   laneCode = `MWSI_WIDTH_DUAL;
            `MWSI_WIDTH_QUAD:   laneCode = qe ? `MWSI_WIDTH_QUAD : `MWSI_WIDTH_DUAL;
            default:            laneCode = `MWSI_WIDTH_NONE;
         endcase
      end
   endfunction

   // Enables of the returning lanes, low while driven
   function [3:0] laneOe_n;
      input [1:0] code;
      begin
         case (code)
            `MWSI_WIDTH_SINGLE: laneOe_n = 4'hD;
            `MWSI_WIDTH_DUAL:   laneOe_n = 4'hC;
            `MWSI_WIDTH_QUAD:   laneOe_n = 4'h0;
            default:            laneOe_n = 4'hF;
         endcase
      end
   endfunction

   // Bits taken from the pins
   function [3:0] laneIn;
      input [1:0] code;
      input [3:0] pins;
      begin
         case (code)
            `MWSI_WIDTH_SINGLE: laneIn = {3'h0, pins[0]};
            `MWSI_WIDTH_DUAL:   laneIn = {2'h0, pins[1:0]};
            `MWSI_WIDTH_QUAD:   laneIn = pins;
            default:            laneIn = 4'h0;
         endcase
      end
   endfunction

   // Pin values that carry the returned bits
   function [3:0] laneOut;
      input [1:0] code;
      input [3:0] data;
      begin
         case (code)
            `MWSI_WIDTH_SINGLE: laneOut = {2'h0, data[0], 1'b0};
            `MWSI_WIDTH_DUAL:   laneOut = {2'h0, data[1:0]};
            `MWSI_WIDTH_QUAD:   laneOut = data;
            default:            laneOut = 4'h0;
         endcase
      end
   endfunction

   wire       rise     = sck && !sckPrev;
   wire       fall     = !sck && sckPrev;
   wire [1:0] nextRole = role3(quadEnableBit, resetSelectBit, cs_n);
   wire [1:0] lanes    = laneCode(xferWidth, quadEnableBit);
   wire       holding  = pauseActive || pauseReq;
   wire       active   = !cs_n && !holding;
   reg  [3:0] next_oe_n;

   always @*
   begin
      next_oe_n = 4'hF;
      if (active && returnPhase)
         next_oe_n = laneOe_n(lanes);
   end

   //*******************************************
   // Serial clock edges and pause
   //*******************************************
   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         sckPrev     <= 1'b0;
         pauseReq    <= 1'b0;
         pauseActive <= 1'b0;
      end
      else
      begin
         sckPrev  <= sck;
         // Pause starts and ends with the serial clock low, but deselect or a role change ends it at once
         pauseReq <= !cs_n && (nextRole == `MWSI_P3_PAUSE) && !pinIn[3];
         if (cs_n || nextRole != `MWSI_P3_PAUSE)
            pauseActive <= 1'b0;
         else if (!sck)
            pauseActive <= pauseReq;
      end
   end

   //*******************************************
   // Roles of the shared pins
   //*******************************************
   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         writeProtect_n <= 1'b1;
         hwReset_n      <= 1'b1;
         pinThreeRole   <= `MWSI_P3_PAUSE;
      end
      else
      begin
         pinThreeRole   <= nextRole;
         writeProtect_n <= quadEnableBit ? 1'b1 : pinIn[2];
         hwReset_n      <= (nextRole == `MWSI_P3_RESET) ? pinIn[3] : 1'b1;
      end
   end

   //*******************************************
   // Capture on rising serial clock
   //*******************************************
   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         rxData  <= 4'h0;
         rxValid <= 1'b0;
      end
      else
      begin
         rxValid <= 1'b0;
         if (active && rise && !returnPhase && lanes != `MWSI_WIDTH_NONE)
         begin
            rxValid <= 1'b1;
            rxData  <= laneIn(lanes, pinIn);
         end
      end
   end

   //*******************************************
   // Return after falling serial clock
   //*******************************************
   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         txTake      <= 1'b0;
         dataPinOut  <= 4'h0;
         dataPinOe_n <= 4'hF;
      end
      else
      begin
         txTake      <= 1'b0;
         dataPinOe_n <= next_oe_n;
         if (active && fall && returnPhase && lanes != `MWSI_WIDTH_NONE)
         begin
            txTake     <= 1'b1;
            dataPinOut <= laneOut(lanes, returnData);
         end
      end
   end
endmodule

// file: logic/mwsi_pin_regs.vh
// Constants for the multi-width serial interface pin function select
`ifndef MWSI_PIN_REGS_VH
`define MWSI_PIN_REGS_VH
// Transfer width codes
`define MWSI_WIDTH_SINGLE 2'h0
`define MWSI_WIDTH_DUAL   2'h1
`define MWSI_WIDTH_QUAD   2'h2
`define MWSI_WIDTH_NONE   2'h3
// Reset values of configuration bits
`define MWSI_QUAD_EN_RST  1'h0
`define MWSI_RST_SEL_RST  1'h0
// Function roles of the fourth pin
`define MWSI_P3_PAUSE     2'h0
`define MWSI_P3_RESET     2'h1
`define MWSI_P3_DATA      2'h2
`define MWSI_P3_NONE      2'h3
// Synchroniser depth
`define MWSI_SYNC_STAGES  2
// Idle levels of serial clock, chip select and the four shared pins
`define MWSI_SYNC_RST     6'h1F
`endif

// file: logic/mwsi_sync.v
// Two-stage synchroniser for a bus of pin levels
`timescale 1ns/10ps
module mwsi_sync
#(
   parameter WIDTH = 1
)
(
   input  wire             mclk,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] din,
   input  wire [WIDTH-1:0] rstVal,
   output reg  [WIDTH-1:0] dout
);
   reg [WIDTH-1:0] stage1;

   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         stage1 <= rstVal;
         dout   <= rstVal;
      end
      else
      begin
         stage1 <= din;
         dout   <= stage1;
      end
   end
endmodule

// file: tb/mwsi_pin_select_sva.sv
// Checker of the shared pin roles
`timescale 1ns/10ps
module mwsi_pin_select_sva
(
   input wire       mclk,
   input wire       rst_n,
   input wire       csPin_n,
   input wire [3:0] dataPinIn,
   input wire [3:0] dataPinOe_n,
   input wire       quadEnableBit,
   input wire       resetSelectBit,
   input wire [1:0] xferWidth,
   input wire       returnPhase,
   input wire       rxValid,
   input wire       writeProtect_n,
   input wire       pauseActive,
   input wire [1:0] pinThreeRole
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_off; csPin_n [*4]; endsequence
   property p_off; s_off |-> dataPinOe_n == 4'hF; endproperty
   a_off: assert property (p_off) else $error("pins driven while deselected");
   property p_noRx; s_off ##1 csPin_n [*2] |-> !rxValid; endproperty
   a_noRx: assert property (p_noRx) else $error("capture while deselected");
   property p_wpQ; quadEnableBit [*4] |-> writeProtect_n; endproperty
   a_wpQ: assert property (p_wpQ) else $error("protect kept in quad");
   property p_wp; (!quadEnableBit && !dataPinIn[2]) [*4] |-> !writeProtect_n; endproperty
   a_wp: assert property (p_wp) else $error("protect not followed");
   property p_rst; (resetSelectBit && (!quadEnableBit || csPin_n)) [*4] |-> pinThreeRole == 2'h1;
   endproperty
   a_rst: assert property (p_rst) else $error("pin three not reset");
   property p_pause; resetSelectBit [*4] |-> !pauseActive; endproperty
   a_pause: assert property (p_pause) else $error("pause with reset select");
   property p_hi; !quadEnableBit [*4] |-> dataPinOe_n[3:2] == 2'h3; endproperty
   a_hi: assert property (p_hi) else $error("upper lanes driven");
   property p_one; (xferWidth == 2'h0) [*4] |-> dataPinOe_n[0]; endproperty
   a_one: assert property (p_one) else $error("pin zero driven in single");
   property p_ret; !returnPhase [*4] |-> dataPinOe_n == 4'hF; endproperty
   a_ret: assert property (p_ret) else $error("pins driven outside return");
   property p_pulse; rxValid |=> !rxValid; endproperty
   a_pulse: assert property (p_pulse) else $error("capture pulse too long");
endmodule
bind mwsi_pin_select mwsi_pin_select_sva i_sva (.mclk, .rst_n, .csPin_n, .dataPinIn,
   .dataPinOe_n, .quadEnableBit, .resetSelectBit, .xferWidth, .returnPhase, .rxValid,
   .writeProtect_n, .pauseActive, .pinThreeRole);

// file: tb/mwsi_host.sv
// Host serial controller model
`timescale 1ns/10ps
module mwsi_host
(
   input  wire       mclk,
   output reg        sck,
   output reg        cs_n,
   output reg  [3:0] dOut
);
   initial
   begin
      sck  <= 1'b0;
      cs_n <= 1'b1;
      dOut <= 4'hF;
   end
   task pause8;
      repeat (8) @(posedge mclk);
   endtask
   // One serial clock with data set up while low
   task clock(input [3:0] d);
   begin
      dOut <= d;
      pause8;
      sck <= 1'b1;
      pause8;
      sck <= 1'b0;
      pause8;
   end
   endtask
   task select(input s);
   begin
      cs_n <= s;
      pause8;
   end
   endtask
endmodule

// file: tb/testbench.sv
// Self-checking bench for the shared pin roles
`timescale 1ns/10ps
module testbench;
   reg        mclk;
   reg        rst_n;
   reg        qe;
   reg        rs;
   reg  [1:0] wd;
   reg        ret;
   reg  [3:0] rd;
   reg  [3:0] got = 4'h0;
   reg  [3:0] takes = 4'h0;
   wire       sck, cs_n, rxV, tk, wp_n, pa, hr_n;
   wire [3:0] hd, pins, dOut, oe_n, rx;
   wire [1:0] role;
   integer    fails = 0;
   integer    checked = 0;
   assign pins = (oe_n & hd) | (~oe_n & dOut);
   mwsi_host i_host (.mclk(mclk), .sck(sck), .cs_n(cs_n), .dOut(hd));
   mwsi_pin_select i_dut (.mclk(mclk), .rst_n(rst_n), .sckPin(sck), .csPin_n(cs_n),
      .dataPinIn(pins), .dataPinOut(dOut), .dataPinOe_n(oe_n), .quadEnableBit(qe),
      .resetSelectBit(rs), .xferWidth(wd), .returnPhase(ret), .returnData(rd),
      .rxData(rx), .rxValid(rxV), .txTake(tk), .writeProtect_n(wp_n), .pauseActive(pa),
      .hwReset_n(hr_n), .pinThreeRole(role));
   always @(posedge mclk)
      if (rxV === 1'b1)
         got <= rx;
   always @(posedge mclk)
      if (tk === 1'b1)
         takes <= takes + 4'h1;
   task chk(input [3:0] g, input [3:0] e);
   begin
      checked = checked + 1;
      if (g !== e)
      begin
         fails = fails + 1;
         $display("unexpected at %0t: %h not %h", $time, g, e);
      end
   end
   endtask
   task conclude;
   begin
      if (fails == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   end
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial
   begin
      #20000;
      fails = fails + 1;
      conclude;
   end
   initial
   begin
      rst_n <= 1'b0;
      qe    <= 1'b0;
      rs    <= 1'b0;
      wd    <= 2'h2;
      ret   <= 1'b0;
      rd    <= 4'h5;
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      i_host.pause8;
      chk(oe_n, 4'hF);
      chk({wp_n, hr_n, role}, 4'hC);
      i_host.select(1'b0);
      i_host.clock(4'hB);
      chk({wp_n, 1'b0, role}, 4'h0);
      qe <= 1'b1;
      i_host.clock(4'hA);
      chk({wp_n, 1'b0, role}, 4'hA);
      chk(got, 4'hA);
      wd <= 2'h1;
      i_host.clock(4'h7);
      chk(got, 4'h3);
      wd <= 2'h2;
      ret <= 1'b1;
      i_host.clock(4'h0);
      chk(dOut, 4'h5);
      chk(oe_n, 4'h0);
      wd <= 2'h0;
      rd <= 4'h3;
      i_host.clock(4'h0);
      chk(oe_n, 4'hD);
      chk(dOut, 4'h2);
      chk(takes, 4'h2);
      i_host.select(1'b1);
      chk(oe_n, 4'hF);
      ret <= 1'b0;
      rs <= 1'b1;
      i_host.clock(4'h7);
      chk({1'b0, hr_n, role}, 4'h1);
      i_host.select(1'b0);
      chk({1'b0, hr_n, role}, 4'h6);
      qe <= 1'b0;
      i_host.pause8;
      chk({1'b0, hr_n, role}, 4'h1);
      rs <= 1'b0;
      i_host.clock(4'h7);
      chk({3'h0, pa}, 4'h1);
      conclude;
   end
endmodule
